// ==== dv/cpu_clock_mode_select_sva.sv ====
// assertions on the cpu clock mode selector ports
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_mode_select_sva (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic osc_input_pin_in,
   input wire logic [7:0] port0_upper_byte_in,
   input wire logic cpu_clk_out,
   input wire logic clock_half_phase_out,
   input wire logic [7:0] reset_config_latch_high_out,
   input wire logic [2:0] clock_source_select_out,
   input wire logic pll_enable_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   wire logic [2:0] sel = clock_source_select_out;
   wire logic [7:0] lat = reset_config_latch_high_out;
   // configuration capture and hold
   a_sel_from_latch: assert property (sel == lat[7:5])
      else $error("select differs from latch");
   a_latch_capture: assert property (disable iff (1'b0) srst_in |=> lat == $past(port0_upper_byte_in))
      else $error("latch missed pins");
   a_latch_hold: assert property ($past(!srst_in) |-> $stable(lat))
      else $error("latch moved");
   a_pll_code: assert property (pll_enable_out == (sel != 3'h3 && sel != 3'h1))
      else $error("pll enable wrong");
   // clock paths
   a_direct_follow: assert property (
      sel == 3'h3 && !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3)
      |-> cpu_clk_out == $past(osc_input_pin_in, 2))
      else $error("direct clock off");
   a_half_phase: assert property (clock_half_phase_out == (cpu_clk_out != $past(cpu_clk_out)))
      else $error("phase pulse wrong");
   a_prescale_edge: assert property (sel == 3'h1 && $rose(osc_input_pin_in) |-> ##[1:4] $changed(cpu_clk_out))
      else $error("prescale missed");
   a_idle_quiet: assert property ((!pll_enable_out && $stable(osc_input_pin_in)) [*5] |-> $stable(cpu_clk_out))
      else $error("edge without input");
   // main scenarios
   c_direct: cover property (sel == 3'h3 && clock_half_phase_out);
   c_prescale: cover property (sel == 3'h1 && clock_half_phase_out);
   c_pll: cover property (pll_enable_out && clock_half_phase_out);
endmodule : cpu_clock_mode_select_sva
`default_nettype wire

// ==== dv/cpu_clock_mode_select_tb_top.sv ====
// testbench for the cpu clock mode selector
`timescale 1ns/1ps
`default_nettype none
`include "cpu_clock_mode_select_params.svh"
module cpu_clock_mode_select_tb_top;
   logic ref_clk_in, srst_in, run, cpu_clk, phase, pll_en;
   logic [7:0] port_byte, latch;
   logic [2:0] sel;
   logic [5:0] hi, lo;
   wire logic osc;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   cpu_clock_mode_select DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .osc_input_pin_in(osc),
      .port0_upper_byte_in(port_byte), .cpu_clk_out(cpu_clk), .clock_half_phase_out(phase),
      .reset_config_latch_high_out(latch), .clock_source_select_out(sel), .pll_enable_out(pll_en));
   osc_source u_osc (.ref_clk_in(ref_clk_in), .run_in(run), .half_hi_in(hi), .half_lo_in(lo), .osc_out(osc));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   // hang guard
   always @(posedge ref_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 10000)
      begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         final_report();
      end
   end
   task chk(input bit ok, input string m);
      check_count++;
      if (!ok)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task final_report;
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // long reset with a code on the pins, then pins change
   task do_reset(input logic [2:0] code);
      @(negedge ref_clk_in);
      run = 1'b0;
      srst_in = 1'b1;
      port_byte = {code, 5'h0A};
      repeat (8) @(negedge ref_clk_in);
      srst_in = 1'b0;
      port_byte = ~port_byte;
      repeat (2) @(negedge ref_clk_in);
      chk(latch === {code, 5'h0A} && sel === code, "latch");
      chk(pll_en === (code != 3'h3 && code != 3'h1), "pll enable");
   endtask : do_reset
   task run_osc(input logic [5:0] h, input logic [5:0] l);
      hi = h;
      lo = l;
      run = 1'b1;
   endtask : run_osc
   // cycles from one phase pulse to the next
   task gap(output int g);
      g = 0;
      for (int i = 0; i < 200 && phase !== 1'b1; i++) @(negedge ref_clk_in);
      do
      begin
         @(negedge ref_clk_in);
         g++;
      end
      while (phase !== 1'b1 && g < 200);
   endtask : gap
   task cnt(input int n, output int c);
      c = 0;
      repeat (n)
      begin
         @(negedge ref_clk_in);
         if (phase === 1'b1) c++;
      end
   endtask : cnt
   task t_direct;
      int a, b;
      do_reset(3'h3);
      run_osc(6'h03, 6'h05);
      gap(a);
      gap(a);
      gap(b);
      chk(a + b == 8 && a * b == 15, "direct halves");
      run = 1'b0;
      repeat (20) @(negedge ref_clk_in);
   endtask : t_direct
   task t_prescale;
      int a, b;
      logic v;
      do_reset(3'h1);
      run_osc(6'h02, 6'h04);
      gap(a);
      v = cpu_clk;
      gap(a);
      gap(b);
      chk(a == 6 && b == 6, "prescale halves");
      chk(cpu_clk === v, "prescale level");
   endtask : t_prescale
   task t_pll;
      logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
      logic [3:0] f2 [6] = '{`F2_X4, `F2_X3, `F2_X2, `F2_X5, `F2_X1P5, `F2_X2P5};
      int c;
      foreach (codes[k])
      begin
         do_reset(codes[k]);
         cnt(60, c);
         chk(c == 0, "edge before input");
         run_osc(6'h14, 6'h14);
         cnt(400, c);
         cnt(320, c);
         chk(c >= 6 * f2[k] && c <= 10 * f2[k], "pll rate");
      end
   endtask : t_pll
   initial
   begin
      srst_in = 1'b1;
      port_byte = 8'hE0;
      run = 1'b0;
      hi = 6'h01;
      lo = 6'h01;
      repeat (8) @(negedge ref_clk_in);
      t_direct();
      t_prescale();
      t_pll();
      final_report();
   end
endmodule : cpu_clock_mode_select_tb_top
bind cpu_clock_mode_select cpu_clock_mode_select_sva u_sva (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
   .osc_input_pin_in(osc_input_pin_in), .port0_upper_byte_in(port0_upper_byte_in), .cpu_clk_out(cpu_clk_out),
   .clock_half_phase_out(clock_half_phase_out), .reset_config_latch_high_out(reset_config_latch_high_out),
   .clock_source_select_out(clock_source_select_out), .pll_enable_out(pll_enable_out));
`default_nettype wire

// ==== dv/osc_source.sv ====
// oscillator model driving the oscillator input pin
`timescale 1ns/1ps
`default_nettype none
module osc_source (
   input wire logic ref_clk_in,
   input wire logic run_in,
   input wire logic [5:0] half_hi_in,
   input wire logic [5:0] half_lo_in,
   output logic osc_out
);
   logic [5:0] n;
   initial osc_out = 1'b0;
   initial n = 6'h01;
   // stands still low outside a run; each level lasts its count
   always @(negedge ref_clk_in)
   begin
      if (!run_in)
      begin
         osc_out <= 1'b0;
         n <= 6'h01;
      end
      else if (n >= (osc_out ? half_hi_in : half_lo_in))
      begin
         osc_out <= !osc_out;
         n <= 6'h01;
      end
      else
         n <= n + 6'h01;
   end
endmodule : osc_source
`default_nettype wire

// ==== logic/cpu_clock_mode_select.sv ====
// cpu clock generation: direct drive, 2:1 prescaler or multiplier
`timescale 1ns/1ps
`default_nettype none
`include "cpu_clock_mode_select_params.svh"
module cpu_clock_mode_select #(
   parameter int CNT_W = 16
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic osc_input_pin_in,
   input wire logic [7:0] port0_upper_byte_in,
   output logic cpu_clk_out,
   output logic clock_half_phase_out,
   output logic [7:0] reset_config_latch_high_out,
   output logic [2:0] clock_source_select_out,
   output logic pll_enable_out
);
   // whole selector state; latch, mode, factor and pll_en only move in reset
   // osc_s and osc_p delay the pin so that edges are seen one cycle apart
   // pcnt counts reference cycles since the last rise, est is the smoothed period
   // armed marks that one rise was seen, so the next rise closes a whole period
   typedef struct packed
   {
      logic [7:0] latch;
      cpu_clock_pkg::clk_mode_t mode;
      logic pll_en;
      logic [3:0] f2;
      logic osc_s;
      logic osc_p;
      logic armed;
      logic [CNT_W-1:0] pcnt;
      logic [CNT_W-1:0] est;
      logic [3:0] tcnt;
      logic sync;
      logic cpu;
      logic phase;
   } state_t;

   state_t q;
   state_t d;
   logic acc_tog;
   logic rise;
   logic edge_seen;
   logic [2:0] sel;
   logic [CNT_W-1:0] meas;

   // paces the multiplied clock from the smoothed period estimate
   // held clear outside multiplier mode and while no period has been measured
   phase_accum #(
      .W(CNT_W)
   ) u_accum (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .en_in(q.mode == cpu_clock_pkg::MODE_PLL),
      .step_in(q.f2),
      .limit_in(q.est),
      .sync_in(q.sync),
      .toggle_out(acc_tog)
   );

   // next state of the whole selector
   always_comb
   begin
      d = q;
      d.phase = 1'b0;
      d.sync = 1'b0;
      rise = q.osc_s & ~q.osc_p;
      edge_seen = q.osc_s ^ q.osc_p;
      // saturating, so a stopped input never wraps to a short period
      meas = (q.pcnt == '1) ? q.pcnt : q.pcnt + {{(CNT_W - 1){1'b0}}, 1'b1};
      sel = srst_in ? port0_upper_byte_in[`CLK_SEL_MSB:`CLK_SEL_LSB] : q.latch[`CLK_SEL_MSB:`CLK_SEL_LSB];
      if (srst_in)
      begin
         // every edge in reset reloads the latch; the last one wins
         d.latch = port0_upper_byte_in; // capture pins while reset is held
         d.osc_s = 1'b0;
         d.osc_p = 1'b0;
         d.pcnt = '0;
         d.est = '0;
         d.tcnt = 4'h0;
         d.cpu = 1'b0;
         d.armed = 1'b0;
         // decode of the selection field
         case (sel)
            `CLK_SEL_X4:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X4;
            end
            `CLK_SEL_X3:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X3;
            end
            `CLK_SEL_X2:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X2;
            end
            `CLK_SEL_X5:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X5;
            end
            `CLK_SEL_X1P5:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X1P5;
            end
            `CLK_SEL_X2P5:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X2P5;
            end
            `CLK_SEL_DIRECT:
            begin
               d.mode = cpu_clock_pkg::MODE_DIRECT; // multiplier off
               d.f2 = 4'h2;
            end
            `CLK_SEL_PRESCALE:
            begin
               d.mode = cpu_clock_pkg::MODE_PRESCALE;
               d.f2 = 4'h1;
            end
            default:
            begin
               d.mode = cpu_clock_pkg::MODE_PLL;
               d.f2 = `F2_X4;
            end
         endcase
         // own flop, so the enable output needs no decode behind it
         d.pll_en = (d.mode == cpu_clock_pkg::MODE_PLL);
      end
      else
      begin
         // latch and mode are left alone until the next reset
         d.osc_s = osc_input_pin_in;
         d.osc_p = q.osc_s;
         // oscillator period in reference cycles, saturating
         if (rise)
         begin
            d.pcnt = '0;
            d.armed = 1'b1;
            if (!q.armed)
            begin
               d.est = q.est; // time since reset is not a period
            end
            else if (q.est == '0)
            begin
               d.est = meas;
            end
            else if (meas > q.est)
            begin
               d.est = q.est + {{(CNT_W - 1){1'b0}}, 1'b1}; // one step per period
            end
            else if (meas < q.est)
            begin
               d.est = q.est - {{(CNT_W - 1){1'b0}}, 1'b1}; // one step per period
            end
         end
         else if (q.pcnt != '1)
         begin
            d.pcnt = meas;
         end
         // counts only in multiplier mode and restarts at every reset
         // resync pulse on each f2-th input transition
         if (edge_seen && (q.mode == cpu_clock_pkg::MODE_PLL))
         begin
            if (q.tcnt >= (q.f2 - 4'h1))
            begin
               d.tcnt = 4'h0;
               d.sync = 1'b1;
            end
            else
            begin
               d.tcnt = q.tcnt + 4'h1;
            end
         end
         // cpu clock source per mode
         case (q.mode)
            cpu_clock_pkg::MODE_DIRECT:
            begin
               // a fixed two cycle delay keeps each half as long as the input's
               d.cpu = q.osc_s; // both half periods copy the input
            end
            cpu_clock_pkg::MODE_PRESCALE:
            begin
               d.cpu = rise ? ~q.cpu : q.cpu; // half period = one input period
            end
            cpu_clock_pkg::MODE_PLL:
            begin
               // idle until a whole input period has been measured
               d.cpu = acc_tog ? ~q.cpu : q.cpu;
            end
            default:
            begin
               d.cpu = q.cpu;
            end
         endcase
         // the pulse stands in the first cycle that shows the new level
         d.phase = d.cpu ^ q.cpu; // every cpu edge starts a phase
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      q <= d;
   end

   // outputs straight from state flops
   assign cpu_clk_out = q.cpu;
   assign clock_half_phase_out = q.phase;
   assign reset_config_latch_high_out = q.latch;
   assign clock_source_select_out = q.latch[`CLK_SEL_MSB:`CLK_SEL_LSB];
   // select is a slice of the latch flop, so it stands with it
   assign pll_enable_out = q.pll_en;
endmodule : cpu_clock_mode_select
`default_nettype wire

// ==== logic/cpu_clock_mode_select_params.svh ====
// constants for the cpu clock mode selector
// Overview of operation
// - both cpu clock edges mark a timing phase; each half period is one phase
// - clock generation mode comes from bits 7..5 of the reset configuration latch
// - long hardware reset loads the latch from port 0 upper byte pins
// - 111 x4 default, 110 x3, 101 x2, 100 x5, 010 x1.5, 000 x2.5
// - 011 disables the multiplier; cpu clock follows the oscillator directly
// - 001 divides the oscillator by two; each half period is one input period
// - multiplier resynchronises every 2F-th input transition and adjusts gradually
// - direct drive: two consecutive half periods equal one oscillator period
`ifndef CPU_CLOCK_MODE_SELECT_PARAMS_SVH
`define CPU_CLOCK_MODE_SELECT_PARAMS_SVH

// selection field position inside the latch
`define CLK_SEL_MSB 7
`define CLK_SEL_LSB 5

// selection codes
`define CLK_SEL_X4 3'h7
`define CLK_SEL_X3 3'h6
`define CLK_SEL_X2 3'h5
`define CLK_SEL_X5 3'h4
`define CLK_SEL_DIRECT 3'h3
`define CLK_SEL_X1P5 3'h2
`define CLK_SEL_PRESCALE 3'h1
`define CLK_SEL_X2P5 3'h0

// twice the multiplier factor, so fractional factors stay integer
`define F2_X4 4'h8
`define F2_X3 4'h6
`define F2_X2 4'h4
`define F2_X5 4'hA
`define F2_X1P5 4'h3
`define F2_X2P5 4'h5

// reset value and reference clock period
`define LATCH_RST 8'h00
`define REF_CLK_PERIOD_NS 50

`endif

// ==== logic/cpu_clock_pkg.sv ====
// types shared by the cpu clock mode selector
`default_nettype none
package cpu_clock_pkg;
   typedef enum logic [1:0]
   {
      MODE_DIRECT,
      MODE_PRESCALE,
      MODE_PLL
   } clk_mode_t;
endpackage : cpu_clock_pkg
`default_nettype wire

// ==== logic/phase_accum.sv ====
// phase accumulator that paces the multiplied cpu clock edges
`timescale 1ns/1ps
`default_nettype none
module phase_accum #(
   parameter int W = 16
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic en_in,
   input wire logic [3:0] step_in,
   input wire logic [W-1:0] limit_in,
   input wire logic sync_in,
   output logic toggle_out
);
   typedef struct packed
   {
      logic [W-1:0] acc;
      logic tog;
   } acc_state_t;

   acc_state_t q;
   acc_state_t d;
   logic [W:0] sum;

   // adds step each cycle; each wrap past the limit yields one cpu edge
   always_comb
   begin
      d = q;
      d.tog = 1'b0;
      sum = {1'b0, q.acc} + {{(W - 3){1'b0}}, step_in};
      if (srst_in || !en_in || (limit_in == '0))
      begin
         d.acc = '0;
      end
      else
      begin
         if (sync_in)
         begin
            sum = {2'b00, q.acc[W-1:1]} + {{(W - 3){1'b0}}, step_in}; // halve phase error, no jump
         end
         if (sum >= {1'b0, limit_in})
         begin
            sum = sum - {1'b0, limit_in};
            d.tog = 1'b1;
         end
         d.acc = (sum >= {1'b0, limit_in}) ? '0 : sum[W-1:0];
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      q <= d;
   end

   assign toggle_out = q.tog;
endmodule : phase_accum
`default_nettype wire
